//--- rtl/pse_port_control_write_regs.sv
// Write-side control register bank for a four-port power sourcing manager
`timescale 1ns/10ps

// Contract
// - Command selects register and port
// - Test bit 6 forces thermal shutdown
// - Test bit 5 holds reset inactive
// - Test bit 4 disables discovery timers
// - Test bit 3 halts all discovery
// - Test bit 2 zeroes DC disconnect delay
// - Test bit 1 disables recovery timer
// - Thermal disable locked after device probe
// - Common bits 4,3 drive AC outputs
// - Common bit 2 disables UV/OV faults
// - Common bit 1 shuts all ports
// - Common bit 0 resets, restarts timing
// - Port bit 5 disables discovery limits
// - Port bit 4 disables DC disconnect
// - Codes 0-2 disable, discover one, two
// - Codes 3-5 voltage, legacy, classify
// - Codes 6-8 ramp, continuous, ramp down
// - Codes 9-C AC, current, temperature
// - Codes D-F spare, do nothing
// - Per-port registers chosen by port
// - Second port bit 4 disables port
// - A/D start bit self clears
// - Second port bit 2 aborts A/D
module pse_port_control_write_regs #(
  parameter int DISC_TICKS = pse_ctrl_pkg::DISC_CYCLES,
  parameter int DCDISC_TICKS = pse_ctrl_pkg::DCDISC_CYCLES,
  parameter int RECOVERY_TICKS = pse_ctrl_pkg::RECOVERY_CYCLES,
  parameter int POR_TICKS = pse_ctrl_pkg::POR_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_valid,
  input wire logic [7:0] wr_command,
  input wire logic [7:0] wr_data,
  input wire logic device_probed,
  input wire logic [3:0] port_low_current,
  input wire logic [3:0] port_fault_event,
  output logic por_active,
  output logic [3:0] port_power_off,
  output logic [3:0] port_fast_off,
  output logic thermal_shutdown,
  output logic thermal_fault_disable,
  output logic upper_ac_drive,
  output logic lower_ac_drive,
  output logic uvov_fault_disable,
  output logic [3:0] disc_fault_disable,
  output logic [3:0] dc_disconnect_disable,
  output logic [15:0] port_function,
  output logic [3:0] disc_halt,
  output logic [3:0] disc_phase_done,
  output logic [3:0] dc_disconnect,
  output logic [3:0] recovery_done,
  output logic [3:0] adc_start,
  output logic [3:0] adc_abort,
  output logic [3:0] port_disable
);

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [3:0] sel;
  logic [1:0] port;
  logic wr_common;
  logic wr_func;
  logic wr_enadc;
  logic wr_test;
  logic [7:0] test_override;
  logic [7:0] common_control;
  logic [7:0] pf_reg [4];
  logic [7:0] pe_reg [4];
  logic soft_reset;
  logic [31:0] por_count;

  assign sel = wr_command[pse_ctrl_pkg::CMD_SEL_LSB +: 4];
  assign port = wr_command[pse_ctrl_pkg::CMD_PORT_LSB +: 2];
  assign wr_common = wr_valid && (sel == pse_ctrl_pkg::SEL_COMMON_CONTROL);
  assign wr_func = wr_valid && (sel == pse_ctrl_pkg::SEL_PORT_FUNCTION);
  assign wr_enadc = wr_valid && (sel == pse_ctrl_pkg::SEL_PORT_ENABLE_ADC);
  assign wr_test = wr_valid && (sel == pse_ctrl_pkg::SEL_TEST_OVERRIDE);
  assign soft_reset = wr_common && wr_data[pse_ctrl_pkg::CC_SW_RESET];

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Counter expired; compare, not equality, so a saturated count stays done
  function automatic logic reached(input logic [31:0] cnt, input int lim);
    reached = (cnt >= 32'(lim));
  endfunction

  // Function field of a port register
  function automatic logic [3:0] func_code(input logic [7:0] r);
    func_code = r[3:0];
  endfunction

  // Command addresses this port
  function automatic logic port_hit(input logic [1:0] p, input int idx);
    port_hit = (p == 2'(idx));
  endfunction

  // ---------------------------------------------------------------
  // Power-on reset timing
  // ---------------------------------------------------------------
  // restart reset timing
  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      por_count <= '0;
    end else if (!reached(por_count, POR_TICKS)) begin
      por_count <= por_count + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    // Soft reset restarts the timing just as power-up does
    if (!rstn || soft_reset) begin
      por_active <= 1'b1;
    end else begin
      por_active <= !test_override[pse_ctrl_pkg::TST_POR_HOLD]
        && !reached(por_count, POR_TICKS);
    end
  end

  // ---------------------------------------------------------------
  // Common registers
  // ---------------------------------------------------------------
  // preset zero
  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      test_override <= pse_ctrl_pkg::REG_RESET;
    end else if (wr_test) begin
      test_override <= wr_data & pse_ctrl_pkg::TEST_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      common_control <= pse_ctrl_pkg::REG_RESET;
    end else if (wr_common) begin
      common_control <= (wr_data & pse_ctrl_pkg::CC_MASK);
      if (device_probed) begin
        common_control[pse_ctrl_pkg::CC_THERMAL_DIS] <=
          common_control[pse_ctrl_pkg::CC_THERMAL_DIS];
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-port registers
  // ---------------------------------------------------------------
  // port addressed copies
  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        pf_reg[i] <= pse_ctrl_pkg::REG_RESET;
        pe_reg[i] <= pse_ctrl_pkg::REG_RESET;
      end
    end else begin
      if (wr_func) begin
        pf_reg[port] <= wr_data & pse_ctrl_pkg::PF_MASK;
      end
      if (wr_enadc) begin
        pe_reg[port] <= wr_data & pse_ctrl_pkg::PE_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      adc_start <= '0;
    end else begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        adc_start[i] <= wr_enadc && port_hit(port, i)
          && wr_data[pse_ctrl_pkg::PE_ADC_START];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      thermal_shutdown <= 1'b0;
      thermal_fault_disable <= 1'b0;
      upper_ac_drive <= 1'b0;
      lower_ac_drive <= 1'b0;
      uvov_fault_disable <= 1'b0;
      disc_halt <= '0;
    end else begin
      thermal_shutdown <= test_override[pse_ctrl_pkg::TST_THERMAL];
      thermal_fault_disable <= common_control[pse_ctrl_pkg::CC_THERMAL_DIS];
      upper_ac_drive <= common_control[pse_ctrl_pkg::CC_UPPER_AC];
      lower_ac_drive <= common_control[pse_ctrl_pkg::CC_LOWER_AC];
      uvov_fault_disable <= common_control[pse_ctrl_pkg::CC_UVOV_DIS];
      disc_halt <= {4{test_override[pse_ctrl_pkg::TST_DISC_HALT]}};
    end
  end

  // Ports come up off; safe state until reset timing ends
  always_ff @(posedge clk) begin
    if (!rstn) begin
      port_power_off <= '1;
      port_fast_off <= '0;
    end else begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        port_fast_off[i] <= common_control[pse_ctrl_pkg::CC_ALL_OFF];
        port_power_off[i] <= test_override[pse_ctrl_pkg::TST_THERMAL]
          || common_control[pse_ctrl_pkg::CC_ALL_OFF]
          || pe_reg[i][pse_ctrl_pkg::PE_PORT_DIS] || por_active;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      disc_fault_disable <= '0;
      dc_disconnect_disable <= '0;
      port_function <= '0;
    end else begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        disc_fault_disable[i] <= pf_reg[i][pse_ctrl_pkg::PF_DISC_FAULT_DIS];
        dc_disconnect_disable[i] <= pf_reg[i][pse_ctrl_pkg::PF_DC_DISC_DIS];
        // function code out, spares inert downstream
        port_function[4 * i +: 4] <= func_code(pf_reg[i]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      adc_abort <= '0;
      port_disable <= '0;
    end else begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        adc_abort[i] <= pe_reg[i][pse_ctrl_pkg::PE_ADC_ABORT];
        port_disable[i] <= pe_reg[i][pse_ctrl_pkg::PE_PORT_DIS];
      end
    end
  end

  // ---------------------------------------------------------------
  // Per-port timers
  // ---------------------------------------------------------------
  // Separate counters per port; area traded for independent timing
  logic [31:0] disc_cnt [4];
  logic [31:0] dcd_cnt [4];
  logic [31:0] rec_cnt [4];
  logic [3:0] in_disc;

  always_comb begin
    for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
      in_disc[i] = (func_code(pf_reg[i]) == pse_ctrl_pkg::FN_DISCOVERY1)
        || (func_code(pf_reg[i]) == pse_ctrl_pkg::FN_DISCOVERY2);
    end
  end

  // Soft reset restarts every timer with the registers
  // discovery phase timer
  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        disc_cnt[i] <= '0;
      end
      disc_phase_done <= '0;
    end else begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        if (!in_disc[i] || (wr_func && port_hit(port, i))
            || test_override[pse_ctrl_pkg::TST_DISC_TIMERS]) begin
          disc_cnt[i] <= '0;
          disc_phase_done[i] <= 1'b0;
        end else if (!test_override[pse_ctrl_pkg::TST_DISC_HALT]) begin
          if (!reached(disc_cnt[i], DISC_TICKS)) begin
            disc_cnt[i] <= disc_cnt[i] + 32'h1;
          end
          disc_phase_done[i] <= reached(disc_cnt[i] + 32'h1, DISC_TICKS);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        dcd_cnt[i] <= '0;
      end
      dc_disconnect <= '0;
    end else begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        if (!port_low_current[i] || pf_reg[i][pse_ctrl_pkg::PF_DC_DISC_DIS]) begin
          dcd_cnt[i] <= '0;
          dc_disconnect[i] <= 1'b0;
        end else if (test_override[pse_ctrl_pkg::TST_DCDISC_ZERO]) begin
          dc_disconnect[i] <= 1'b1;
        end else begin
          if (!reached(dcd_cnt[i], DCDISC_TICKS)) begin
            dcd_cnt[i] <= dcd_cnt[i] + 32'h1;
          end
          dc_disconnect[i] <= reached(dcd_cnt[i] + 32'h1, DCDISC_TICKS);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || soft_reset) begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        rec_cnt[i] <= '0;
      end
      recovery_done <= '0;
    end else begin
      for (int i = 0; i < pse_ctrl_pkg::NUM_PORTS; i++) begin
        if (port_fault_event[i] || test_override[pse_ctrl_pkg::TST_RECOVERY_OFF]) begin
          rec_cnt[i] <= '0;
          recovery_done[i] <= 1'b0;
        end else begin
          if (!reached(rec_cnt[i], RECOVERY_TICKS)) begin
            rec_cnt[i] <= rec_cnt[i] + 32'h1;
          end
          recovery_done[i] <= reached(rec_cnt[i] + 32'h1, RECOVERY_TICKS);
        end
      end
    end
  end

endmodule

//--- rtl/pse_ctrl_pkg.sv
// Constants for the port control write register bank
package pse_ctrl_pkg;
  // ---------------------------------------------------------------
  // Register select codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SEL_COMMON_CONTROL = 4'h1;
  localparam logic [3:0] SEL_PORT_FUNCTION = 4'h2;
  localparam logic [3:0] SEL_PORT_ENABLE_ADC = 4'h3;
  localparam logic [3:0] SEL_TEST_OVERRIDE = 4'hF;
  // ---------------------------------------------------------------
  // Command byte fields
  // ---------------------------------------------------------------
  localparam int CMD_SEL_LSB = 3;
  localparam int CMD_PORT_LSB = 0;
  localparam int NUM_PORTS = 4;
  // ---------------------------------------------------------------
  // Test override bits
  // ---------------------------------------------------------------
  localparam int TST_THERMAL = 6;
  localparam int TST_POR_HOLD = 5;
  localparam int TST_DISC_TIMERS = 4;
  localparam int TST_DISC_HALT = 3;
  localparam int TST_DCDISC_ZERO = 2;
  localparam int TST_RECOVERY_OFF = 1;
  localparam logic [7:0] TEST_MASK = 8'h7E;
  // ---------------------------------------------------------------
  // Common control bits
  // ---------------------------------------------------------------
  localparam int CC_THERMAL_DIS = 5;
  localparam int CC_UPPER_AC = 4;
  localparam int CC_LOWER_AC = 3;
  localparam int CC_UVOV_DIS = 2;
  localparam int CC_ALL_OFF = 1;
  localparam int CC_SW_RESET = 0;
  localparam logic [7:0] CC_MASK = 8'h3E;
  // ---------------------------------------------------------------
  // Port control bits
  // ---------------------------------------------------------------
  localparam int PF_DISC_FAULT_DIS = 5;
  localparam int PF_DC_DISC_DIS = 4;
  localparam logic [7:0] PF_MASK = 8'h3F;
  localparam int PE_PORT_DIS = 4;
  localparam int PE_ADC_START = 3;
  localparam int PE_ADC_ABORT = 2;
  localparam logic [7:0] PE_MASK = 8'h14;
  localparam logic [7:0] REG_RESET = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DISC_TIME_MS = 4;
  localparam int DCDISC_TIME_MS = 300;
  localparam int RECOVERY_TIME_MS = 750;
  localparam int POR_TIME_US = 100;
  localparam int DISC_CYCLES = DISC_TIME_MS * 1000 * CLK_MHZ;
  localparam int DCDISC_CYCLES = DCDISC_TIME_MS * 1000 * CLK_MHZ;
  localparam int RECOVERY_CYCLES = RECOVERY_TIME_MS * 1000 * CLK_MHZ;
  localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
  // ---------------------------------------------------------------
  // Function codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FN_DISABLE = 4'b0000,
    FN_DISCOVERY1 = 4'b0001,
    FN_DISCOVERY2 = 4'b0010,
    FN_VSAMPLE = 4'b0011,
    FN_LEGACY = 4'b0100,
    FN_CLASSIFY = 4'b0101,
    FN_RAMP_UP = 4'b0110,
    FN_CSAMPLE = 4'b0111,
    FN_RAMP_DOWN = 4'b1000,
    FN_AC_LOWER = 4'b1001,
    FN_AC_UPPER = 4'b1010,
    FN_ISAMPLE = 4'b1011,
    FN_TSAMPLE = 4'b1100
  } function_t;
endpackage

//--- dv/pse_host_model.sv
// Host controller model issuing decoded register writes
`timescale 1ns/10ps
module pse_host_model (
  input wire logic clk,
  output logic wr_valid,
  output logic [7:0] wr_command,
  output logic [7:0] wr_data
);
  initial begin
    wr_valid = 1'b0;
    wr_command = 8'h00;
    wr_data = 8'h00;
  end
  task automatic write(input logic [3:0] sel, input logic [1:0] port, input logic [7:0] data);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_command <= {1'b0, sel, 1'b0, port};
    wr_data <= data;
    @(posedge clk);
    wr_valid <= 1'b0;
    // Released bytes inverted so a stale value cannot pass
    wr_command <= ~{1'b0, sel, 1'b0, port};
    wr_data <= ~data;
  endtask
endmodule

//--- dv/pse_port_control_write_regs_chk.sv
// Assertion checker for the port control write register bank
`timescale 1ns/10ps
module pse_port_control_write_regs_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_valid,
  input wire logic [7:0] wr_command,
  input wire logic [7:0] wr_data,
  input wire logic device_probed,
  input wire logic por_active,
  input wire logic [3:0] port_power_off,
  input wire logic [3:0] port_fast_off,
  input wire logic thermal_shutdown,
  input wire logic thermal_fault_disable,
  input wire logic upper_ac_drive,
  input wire logic lower_ac_drive,
  input wire logic uvov_fault_disable,
  input wire logic [15:0] port_function,
  input wire logic [3:0] disc_halt,
  input wire logic [3:0] adc_start,
  input wire logic [3:0] adc_abort,
  input wire logic [3:0] port_disable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire [3:0] sel = wr_command[6:3];
  wire w_cc = wr_valid && sel == pse_ctrl_pkg::SEL_COMMON_CONTROL;
  wire w_pf = wr_valid && sel == pse_ctrl_pkg::SEL_PORT_FUNCTION;
  wire w_pe = wr_valid && sel == pse_ctrl_pkg::SEL_PORT_ENABLE_ADC;
  wire w_ts = wr_valid && sel == pse_ctrl_pkg::SEL_TEST_OVERRIDE;
  property p_reset_vals;
    $rose(rstn) |-> por_active && port_power_off == 4'hF && port_function == 16'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  property p_sw_reset;
    w_cc && wr_data[0] |-> ##2 por_active && port_function == 16'h0 && !upper_ac_drive;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset missed");
  property p_test_wr;
    w_ts |-> ##2 thermal_shutdown == $past(wr_data[6], 2) && disc_halt == {4{$past(wr_data[3], 2)}};
  endproperty
  a_test_wr: assert property (p_test_wr) else $error("test bits not applied");
  property p_thermal_off;
    $rose(thermal_shutdown) |-> ##[0:1] port_power_off == 4'hF;
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("ports not off");
  property p_ac_bits;
    w_cc && !wr_data[0] |-> ##2 upper_ac_drive == $past(wr_data[4], 2)
      && lower_ac_drive == $past(wr_data[3], 2) && uvov_fault_disable == $past(wr_data[2], 2);
  endproperty
  a_ac_bits: assert property (p_ac_bits) else $error("common bits wrong");
  property p_all_off;
    w_cc && !wr_data[0] |-> ##2 port_fast_off == {4{$past(wr_data[1], 2)}};
  endproperty
  a_all_off: assert property (p_all_off) else $error("fast off wrong");
  property p_probe_lock;
    w_cc && device_probed && !wr_data[0] |-> ##2 thermal_fault_disable == $past(thermal_fault_disable);
  endproperty
  a_probe_lock: assert property (p_probe_lock) else $error("locked bit changed");
  property p_func;
    w_pf |-> ##2 port_function[4 * $past(wr_command[1:0], 2) +: 4] == $past(wr_data[3:0], 2);
  endproperty
  a_func: assert property (p_func) else $error("function code wrong");
  property p_adc_pulse;
    w_pe && wr_data[3] |-> ##1 adc_start[$past(wr_command[1:0])] ##1 adc_start == 4'h0;
  endproperty
  a_adc_pulse: assert property (p_adc_pulse) else $error("start pulse wrong");
  property p_port_dis;
    w_pe |-> ##2 port_disable[$past(wr_command[1:0], 2)] == $past(wr_data[4], 2)
      && adc_abort[$past(wr_command[1:0], 2)] == $past(wr_data[2], 2);
  endproperty
  a_port_dis: assert property (p_port_dis) else $error("port control wrong");
  c_test: cover property (w_ts);
  c_start: cover property (adc_start != 4'h0);
  c_por: cover property ($fell(por_active));
endmodule
bind pse_port_control_write_regs pse_port_control_write_regs_chk chk_u (.*);

//--- dv/pse_port_control_write_regs_tb.sv
// Testbench for the port control write register bank
`timescale 1ns/10ps
module pse_port_control_write_regs_tb;
  localparam logic [3:0] SEL_CC = pse_ctrl_pkg::SEL_COMMON_CONTROL;
  localparam logic [3:0] SEL_PF = pse_ctrl_pkg::SEL_PORT_FUNCTION;
  localparam logic [3:0] SEL_PE = pse_ctrl_pkg::SEL_PORT_ENABLE_ADC;
  localparam logic [3:0] SEL_TS = pse_ctrl_pkg::SEL_TEST_OVERRIDE;
  logic clk, rstn, wr_valid, device_probed, por_active, thermal_shutdown;
  logic thermal_fault_disable, upper_ac_drive, lower_ac_drive, uvov_fault_disable;
  logic [7:0] wr_command, wr_data;
  logic [3:0] port_low_current, port_fault_event, port_power_off, port_fast_off;
  logic [3:0] disc_fault_disable, dc_disconnect_disable, disc_halt, disc_phase_done;
  logic [3:0] dc_disconnect, recovery_done, adc_start, adc_abort, port_disable;
  logic [15:0] port_function;
  logic [7:0] cc_tab [5] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h20};
  int failures;
  int num_checks;
  pse_port_control_write_regs #(.DISC_TICKS(10), .DCDISC_TICKS(20), .RECOVERY_TICKS(12),
    .POR_TICKS(8)) dut_u (.*);
  pse_host_model host_u (.clk(clk), .wr_valid(wr_valid), .wr_command(wr_command),
    .wr_data(wr_data));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrt(input logic [3:0] sel, input logic [1:0] port, input logic [7:0] data);
    host_u.write(sel, port, data);
    tick(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Bounded, a stuck reset timer would hang the run
  task automatic wait_por();
    int i;
    for (i = 0; i < 50 && por_active !== 1'b0; i++) tick(1);
    if (i == 50) begin
      failures++;
      wrap_up();
    end
  endtask
  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    device_probed = 1'b0;
    port_low_current = 4'h0;
    port_fault_event = 4'h0;
    failures = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    tick(0);
    chk("por_active", por_active, 1'b1);
    chk("port_power_off", port_power_off, 4'hF);
    chk("port_function", port_function, 16'h0);
    wait_por();
    for (int c = 0; c < 16; c++) begin
      wrt(SEL_PF, c[1:0], {2'b00, c[1:0], c[3:0]});
      chk("code", port_function[4 * c[1:0] +: 4], c[3:0]);
      chk("disc_fault_disable", disc_fault_disable[c[1:0]], c[1]);
      chk("dc_disconnect_disable", dc_disconnect_disable[c[1:0]], c[0]);
    end
    chk("all codes", port_function, 16'hFEDC);
    for (int i = 0; i < 5; i++) begin
      wrt(SEL_CC, 2'd0, cc_tab[i]);
      chk("ac_uvov", {upper_ac_drive, lower_ac_drive, uvov_fault_disable}, cc_tab[i][4:2]);
      chk("port_fast_off", port_fast_off, {4{cc_tab[i][1]}});
      chk("port_power_off", port_power_off, {4{cc_tab[i][1]}});
      chk("thermal_fault_disable", thermal_fault_disable, cc_tab[i][5]);
    end
    @(posedge clk);
    device_probed <= 1'b1;
    wrt(SEL_CC, 2'd0, 8'h00);
    chk("locked", thermal_fault_disable, 1'b1);
    @(posedge clk);
    device_probed <= 1'b0;
    wrt(SEL_CC, 2'd0, 8'h00);
    chk("unlocked", thermal_fault_disable, 1'b0);
    host_u.write(SEL_PE, 2'd2, 8'h08);
    tick(0);
    chk("adc_start", adc_start, 4'h4);
    tick(1);
    chk("adc_start", adc_start, 4'h0);
    wrt(SEL_PE, 2'd1, 8'h14);
    chk("port_disable", port_disable, 4'h2);
    chk("adc_abort", adc_abort, 4'h2);
    chk("port_power_off", port_power_off, 4'h2);
    wrt(SEL_PE, 2'd1, 8'h00);
    wrt(SEL_PF, 2'd3, 8'h01);
    tick(15);
    chk("disc_phase_done", disc_phase_done[3], 1'b1);
    wrt(SEL_TS, 2'd0, 8'h10);
    wrt(SEL_PF, 2'd3, 8'h00);
    wrt(SEL_PF, 2'd3, 8'h01);
    tick(15);
    chk("disc_phase_done", disc_phase_done[3], 1'b0);
    wrt(SEL_TS, 2'd0, 8'h48);
    chk("thermal_shutdown", thermal_shutdown, 1'b1);
    chk("port_power_off", port_power_off, 4'hF);
    chk("disc_halt", disc_halt, 4'hF);
    wrt(SEL_TS, 2'd0, 8'h00);
    chk("thermal_shutdown", thermal_shutdown, 1'b0);
    wrt(SEL_PF, 2'd0, 8'h06);
    @(posedge clk);
    port_low_current <= 4'h1;
    tick(5);
    chk("dc_disconnect", dc_disconnect[0], 1'b0);
    tick(20);
    chk("dc_disconnect", dc_disconnect[0], 1'b1);
    wrt(SEL_TS, 2'd0, 8'h04);
    wrt(SEL_PF, 2'd1, 8'h06);
    @(posedge clk);
    port_low_current <= 4'h3;
    tick(3);
    chk("dc_disconnect zero delay", dc_disconnect[1], 1'b1);
    @(posedge clk);
    port_fault_event <= 4'h4;
    @(posedge clk);
    port_fault_event <= 4'h0;
    tick(5);
    chk("recovery_done", recovery_done[2], 1'b0);
    tick(10);
    chk("recovery_done", recovery_done[2], 1'b1);
    wrt(SEL_TS, 2'd0, 8'h02);
    chk("recovery_done off", recovery_done, 4'h0);
    wrt(SEL_CC, 2'd0, 8'h01);
    chk("por_active", por_active, 1'b1);
    chk("port_function", port_function, 16'h0);
    wait_por();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    tick(0);
    chk("port_power_off", port_power_off, 4'hF);
    wrt(SEL_TS, 2'd0, 8'h20);
    chk("por_active held", por_active, 1'b0);
    wrap_up();
  end
endmodule
